// ==== rtl/dopcc_pkg.sv ====
package dopcc_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned MCLK_PERIOD_PS = 4000;
    localparam int unsigned FINE_STEP_PS = 150;
    localparam int unsigned FINE_MAX_VAL = 15;
    // Whole step range rounded up to master clock cycles
    localparam int unsigned FINE_MAX_CYC = ((FINE_MAX_VAL + 1) * FINE_STEP_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    // Port A carries feedback plus relative delay
    localparam int unsigned DLY_DEPTH = 2 * FINE_MAX_CYC;
    localparam int unsigned DLY_SEL_W = $clog2(DLY_DEPTH + 1);

    // ==========================================================
    // Lock detection and oscillator model
    // ==========================================================
    localparam int unsigned LOCK_REF_EDGES = 16;
    localparam int unsigned REF_TIMEOUT_CYC = 64;
    localparam logic [2:0] PHASE_DIV_4 = 3'h4;
    localparam logic [2:0] PHASE_DIV_7 = 3'h7;
    localparam logic [2:0] HALF_MIN = 3'h1;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_MAX = 8'hFF;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {RT_SIMPLE, RT_DELAY, RT_PHASE, RT_EXT} dopcc_route_t;
    typedef enum logic {DS_FIXED, DS_RUNTIME} dopcc_dsrc_t;
    typedef enum logic [1:0] {SRC_TAP_ZERO, SRC_TAP_QUARTER, SRC_FULL, SRC_HALVED} dopcc_osrc_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_LOCKED} dopcc_fsm_t;

    typedef struct packed {
        dopcc_route_t route;
        dopcc_dsrc_t fb_fine_delay_src;
        logic [3:0] fb_fine_delay_val;
        dopcc_dsrc_t rel_fine_delay_src;
        logic [3:0] rel_fine_delay_val;
        logic phase_div_sel;
        dopcc_osrc_t out_a_src_sel;
        dopcc_osrc_t out_b_src_sel;
        logic [3:0] ref_divider;
        logic [5:0] fb_divider;
        logic [2:0] osc_out_divider;
        logic [2:0] filter_range;
        logic gate_en_a;
        logic gate_en_b;
    } dopcc_cfg_t;

    typedef struct packed {
        dopcc_fsm_t fsm;
        dopcc_cfg_t cfg;
        logic ref_q;
        logic fb_q;
        logic synth_full;
        logic synth_halved;
        logic [2:0] half_cnt;
        logic [2:0] phase_cnt;
        logic [7:0] edge_cnt;
        logic [7:0] idle_cnt;
        logic fb_seen;
        logic out_a_global_net;
        logic out_a_fabric;
        logic out_b_global_net;
        logic out_b_fabric;
        logic lock;
    } dopcc_state_t;

    // Steps of (n+1) fine units, rounded up to whole cycles
    function automatic logic [DLY_SEL_W-1:0] fine_cycles(input logic [3:0] n);
        int unsigned ps;
        ps = (int'(n) + 1) * FINE_STEP_PS;
        return DLY_SEL_W'((ps + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS);
    endfunction : fine_cycles

endpackage : dopcc_pkg

// ==== rtl/dopcc_fine_delay.sv ====
module dopcc_fine_delay #(
    parameter int unsigned DEPTH = dopcc_pkg::DLY_DEPTH,
    parameter int unsigned SEL_W = dopcc_pkg::DLY_SEL_W
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Data
    input wire logic i_din,
    input wire logic [SEL_W-1:0] i_sel,
    output logic o_dout
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [DEPTH-1:0] line;
    } dopcc_dly_state_t;

    dopcc_dly_state_t st_ff;
    dopcc_dly_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.line = {st_ff.line[DEPTH-2:0], i_din};
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    // Tap zero is the undelayed input; out-of-range taps clamp to the deepest
    always_comb begin
        if (i_sel == '0) begin
            o_dout = i_din;
        end else if (int'(i_sel) > DEPTH) begin
            o_dout = st_ff.line[DEPTH-1];
        end else begin
            o_dout = st_ff.line[int'(i_sel) - 1];
        end
    end

endmodule : dopcc_fine_delay

// ==== rtl/dopcc_top.sv ====
module dopcc_top #(
    parameter int unsigned LOCK_EDGES = dopcc_pkg::LOCK_REF_EDGES,
    parameter int unsigned REF_TIMEOUT = dopcc_pkg::REF_TIMEOUT_CYC,
    parameter int unsigned EXT_DIV_FACTOR = 1
) (
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Static configuration
    input wire dopcc_pkg::dopcc_cfg_t i_cfg,
    // Clocks sampled as levels
    input wire logic i_ref_clk_in,
    input wire logic i_ext_fb_clk_in,
    // Live controls
    input wire logic i_bypass,
    input wire logic i_hold_outputs_req,
    input wire logic [7:0] i_runtime_delay_bus,
    // Generated clocks and status
    output logic o_out_a_global_net,
    output logic o_out_a_fabric,
    output logic o_out_b_global_net,
    output logic o_out_b_fabric,
    output logic o_lock
);

    // ==========================================================
    // Declarations
    // ==========================================================
    dopcc_pkg::dopcc_state_t st_ff;
    dopcc_pkg::dopcc_state_t nxt_st;
    logic ref_rise;
    logic ext_rise;
    logic synth_rise;
    logic fb_rise;
    logic running;
    logic [2:0] half_len;
    logic [2:0] div_len;
    logic [2:0] quarter_cnt;
    logic tap_zero;
    logic tap_quarter;
    logic src_a;
    logic src_b;
    logic dly_a;
    logic dly_b;
    logic freeze_a;
    logic freeze_b;
    logic timed_out;
    logic [7:0] need;
    logic [dopcc_pkg::DLY_SEL_W-1:0] fb_cyc;
    logic [dopcc_pkg::DLY_SEL_W-1:0] rel_cyc;
    logic [dopcc_pkg::DLY_SEL_W-1:0] sel_a;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic pick_src(
        input dopcc_pkg::dopcc_osrc_t sel,
        input dopcc_pkg::dopcc_cfg_t cfg,
        input logic t0,
        input logic t90,
        input logic full,
        input logic halved
    );
        logic r;
        r = 1'b0;
        case (sel)
            dopcc_pkg::SRC_TAP_ZERO: r = (cfg.route == dopcc_pkg::RT_PHASE) & t0;
            dopcc_pkg::SRC_TAP_QUARTER: r = (cfg.route == dopcc_pkg::RT_PHASE) & !cfg.phase_div_sel & t90;
            dopcc_pkg::SRC_FULL: r = full;
            dopcc_pkg::SRC_HALVED: r = halved;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pick_src

    // ==========================================================
    // Edges and oscillator model
    // ==========================================================
    assign running = (st_ff.fsm != dopcc_pkg::ST_IDLE);
    assign ref_rise = i_ref_clk_in & !st_ff.ref_q;
    assign ext_rise = i_ext_fb_clk_in & !st_ff.fb_q;
    // Output divider of zero would stall the model, so it counts as one
    assign half_len = (st_ff.cfg.osc_out_divider == 3'h0) ? dopcc_pkg::HALF_MIN : st_ff.cfg.osc_out_divider;
    assign synth_rise = running & !st_ff.synth_full & (st_ff.half_cnt >= half_len - dopcc_pkg::HALF_MIN);
    // External feedback pin is only looked at on the external route
    assign fb_rise = (st_ff.cfg.route == dopcc_pkg::RT_EXT) ? ext_rise : synth_rise;
    assign div_len = st_ff.cfg.phase_div_sel ? dopcc_pkg::PHASE_DIV_7 : dopcc_pkg::PHASE_DIV_4;
    assign quarter_cnt = (st_ff.phase_cnt == 3'h0) ? div_len - 3'h1 : st_ff.phase_cnt - 3'h1;
    assign tap_zero = st_ff.phase_cnt < (div_len >> 1);
    assign tap_quarter = quarter_cnt < (div_len >> 1);
    assign src_a = pick_src(st_ff.cfg.out_a_src_sel, st_ff.cfg, tap_zero, tap_quarter,
        st_ff.synth_full, st_ff.synth_halved);
    assign src_b = pick_src(st_ff.cfg.out_b_src_sel, st_ff.cfg, tap_zero, tap_quarter,
        st_ff.synth_full, st_ff.synth_halved);

    // ==========================================================
    // Fine delay
    // ==========================================================
    // Simple route sets the feedback delay to zero; port A still takes the relative delay
    assign fb_cyc = (st_ff.cfg.route == dopcc_pkg::RT_SIMPLE) ? '0 : dopcc_pkg::fine_cycles(
        (st_ff.cfg.fb_fine_delay_src == dopcc_pkg::DS_RUNTIME) ? i_runtime_delay_bus[3:0]
        : st_ff.cfg.fb_fine_delay_val);
    assign rel_cyc = dopcc_pkg::fine_cycles(
        (st_ff.cfg.rel_fine_delay_src == dopcc_pkg::DS_RUNTIME) ? i_runtime_delay_bus[7:4]
        : st_ff.cfg.rel_fine_delay_val);
    assign sel_a = dopcc_pkg::DLY_SEL_W'(fb_cyc + rel_cyc);

    dopcc_fine_delay #(
        .DEPTH(dopcc_pkg::DLY_DEPTH),
        .SEL_W(dopcc_pkg::DLY_SEL_W)
    ) u_dly_a (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_din(src_a),
        .i_sel(sel_a),
        .o_dout(dly_a)
    );

    dopcc_fine_delay #(
        .DEPTH(dopcc_pkg::DLY_DEPTH),
        .SEL_W(dopcc_pkg::DLY_SEL_W)
    ) u_dly_b (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_din(src_b),
        .i_sel(fb_cyc),
        .o_dout(dly_b)
    );

    // ==========================================================
    // Low-power hold and lock threshold
    // ==========================================================
    assign freeze_a = i_hold_outputs_req & st_ff.cfg.gate_en_a;
    assign freeze_b = i_hold_outputs_req & st_ff.cfg.gate_en_b;
    assign timed_out = (int'(st_ff.idle_cnt) >= REF_TIMEOUT);
    // Larger dividers and slower filters take longer to settle
    assign need = 8'(LOCK_EDGES * EXT_DIV_FACTOR) + 8'(st_ff.cfg.ref_divider)
        + 8'(st_ff.cfg.fb_divider) + 8'(st_ff.cfg.filter_range);

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ref_q = i_ref_clk_in;
        nxt_st.fb_q = i_ext_fb_clk_in;
        nxt_st.idle_cnt = ref_rise ? 8'h00 : (st_ff.idle_cnt == dopcc_pkg::CNT_MAX ? st_ff.idle_cnt
            : st_ff.idle_cnt + dopcc_pkg::CNT_ONE);
        if (running) begin
            if (st_ff.half_cnt >= half_len - dopcc_pkg::HALF_MIN) begin
                nxt_st.half_cnt = 3'h0;
                nxt_st.synth_full = !st_ff.synth_full;
                if (synth_rise) begin
                    nxt_st.synth_halved = !st_ff.synth_halved;
                    nxt_st.phase_cnt = (st_ff.phase_cnt >= div_len - 3'h1) ? 3'h0 : st_ff.phase_cnt + 3'h1;
                end
            end else begin
                nxt_st.half_cnt = st_ff.half_cnt + 3'h1;
            end
        end
        case (st_ff.fsm)
            dopcc_pkg::ST_IDLE: begin
                // Configuration is captured once after reset and then held
                nxt_st.cfg = i_cfg;
                nxt_st.edge_cnt = 8'h00;
                nxt_st.fb_seen = 1'b0;
                nxt_st.fsm = dopcc_pkg::ST_ACQ;
            end
            dopcc_pkg::ST_ACQ: begin
                if (timed_out) begin
                    nxt_st.edge_cnt = 8'h00;
                    nxt_st.fb_seen = 1'b0;
                end else begin
                    if (fb_rise) begin
                        nxt_st.fb_seen = 1'b1;
                    end
                    if (ref_rise && st_ff.edge_cnt != dopcc_pkg::CNT_MAX) begin
                        nxt_st.edge_cnt = st_ff.edge_cnt + dopcc_pkg::CNT_ONE;
                    end
                    if (st_ff.edge_cnt >= need && st_ff.fb_seen) begin
                        nxt_st.fsm = dopcc_pkg::ST_LOCKED;
                    end
                end
            end
            dopcc_pkg::ST_LOCKED: begin
                // Reference stopped: loop has lost its source
                if (timed_out) begin
                    nxt_st.fsm = dopcc_pkg::ST_ACQ;
                    nxt_st.edge_cnt = 8'h00;
                    nxt_st.fb_seen = 1'b0;
                end
            end
            default: begin
                nxt_st.fsm = dopcc_pkg::ST_IDLE;
            end
        endcase
        // Frozen port B is not tracking the reference, so lock drops
        nxt_st.lock = (nxt_st.fsm == dopcc_pkg::ST_LOCKED) && !freeze_b;
        if (!freeze_a) begin
            nxt_st.out_a_global_net = i_bypass ? i_ref_clk_in : dly_a;
            nxt_st.out_a_fabric = i_bypass ? i_ref_clk_in : dly_a;
        end
        if (!freeze_b) begin
            nxt_st.out_b_global_net = i_bypass ? i_ref_clk_in : dly_b;
            nxt_st.out_b_fabric = i_bypass ? i_ref_clk_in : dly_b;
        end
    end

    // Asynchronous clear; everything else waits for an enabled edge
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_out_a_global_net = st_ff.out_a_global_net;
    assign o_out_a_fabric = st_ff.out_a_fabric;
    assign o_out_b_global_net = st_ff.out_b_global_net;
    assign o_out_b_fabric = st_ff.out_b_fabric;
    assign o_lock = st_ff.lock;

    // ==========================================================
    // Assertions
    // ==========================================================
    fabric_match_a_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        o_out_a_fabric == o_out_a_global_net)
        else $error("port A fabric and global outputs differ");

    fabric_match_b_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        o_out_b_fabric == o_out_b_global_net)
        else $error("port B fabric and global outputs differ");

    lock_gated_b_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && i_hold_outputs_req && st_ff.cfg.gate_en_b) |=> !o_lock)
        else $error("lock high while port B frozen");

    ext_fb_only_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && st_ff.fsm == dopcc_pkg::ST_ACQ && st_ff.cfg.route == dopcc_pkg::RT_EXT && !ext_rise)
        |=> !$rose(st_ff.fb_seen))
        else $error("feedback seen without external edge");

    // State is unknown before the first edge, so look one edge later
    reset_lock_low_a: assert property (@(posedge i_mclk)
        !i_nrst |=> (!o_lock && !o_out_a_global_net && !o_out_b_global_net))
        else $error("outputs not cleared in reset");

    bypass_ref_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && i_bypass && !i_hold_outputs_req) |=> (o_out_a_global_net == $past(i_ref_clk_in)
        && o_out_b_global_net == $past(i_ref_clk_in)))
        else $error("bypass did not pass reference clock");

    freeze_a_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && freeze_a) |=> $stable(o_out_a_global_net))
        else $error("port A changed while frozen");

    freeze_b_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && freeze_b) |=> $stable(o_out_b_global_net))
        else $error("port B changed while frozen");

    no_gate_a_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && i_hold_outputs_req && !st_ff.cfg.gate_en_a && i_bypass)
        |=> o_out_a_global_net == $past(i_ref_clk_in))
        else $error("ungated port A held by hold request");

    phase_range_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        st_ff.phase_cnt < div_len)
        else $error("phase counter beyond divider length");

    lock_after_edges_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $rose(o_lock) |-> ($past(st_ff.edge_cnt) >= $past(need) && $past(st_ff.fb_seen)))
        else $error("lock without enough reference edges");

    acq_no_lock_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (st_ff.fsm != dopcc_pkg::ST_LOCKED) |-> !o_lock)
        else $error("lock high outside locked state");

    ref_loss_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && o_lock && timed_out) |=> !o_lock)
        else $error("lock kept after reference loss");

    no_gate_b_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && i_hold_outputs_req && !st_ff.cfg.gate_en_b && i_bypass)
        |=> o_out_b_global_net == $past(i_ref_clk_in))
        else $error("ungated port B held by hold request");

    // Every fine value rounds up to one master cycle at this clock
    fb_delay_b_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && st_ff.cfg.route != dopcc_pkg::RT_SIMPLE) ##1 (i_ce && !i_bypass && !freeze_b)
        |=> o_out_b_global_net == $past(src_b, 2))
        else $error("port B feedback delay is not one cycle");

    tap_off_route_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && !i_bypass && !freeze_a && st_ff.cfg.route != dopcc_pkg::RT_PHASE
        && st_ff.cfg.out_a_src_sel == dopcc_pkg::SRC_TAP_ZERO) |=> !o_out_a_global_net)
        else $error("port A zero tap active off the phase route");

    quarter_div7_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_ce && !i_bypass && !freeze_b && st_ff.cfg.phase_div_sel
        && st_ff.cfg.out_b_src_sel == dopcc_pkg::SRC_TAP_QUARTER) |=> !o_out_b_global_net)
        else $error("port B quarter tap active with divide by 7");

    cfg_static_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (st_ff.fsm != dopcc_pkg::ST_IDLE) |=> $stable(st_ff.cfg))
        else $error("configuration changed after capture");

    lock_seen_c: cover property (@(posedge i_mclk) disable iff (!i_nrst) $rose(o_lock));

    ext_lock_c: cover property (@(posedge i_mclk) disable iff (!i_nrst)
        $rose(o_lock) && st_ff.cfg.route == dopcc_pkg::RT_EXT);

    div7_tap_c: cover property (@(posedge i_mclk) disable iff (!i_nrst)
        st_ff.cfg.route == dopcc_pkg::RT_PHASE && st_ff.cfg.phase_div_sel && st_ff.phase_cnt == 3'h6);

    bypass_hold_c: cover property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && i_bypass && freeze_a && !freeze_b);

    ref_loss_c: cover property (@(posedge i_mclk) disable iff (!i_nrst) o_lock && timed_out);

endmodule : dopcc_top

// ==== sim/dopcc_fabric_model.sv ====
module dopcc_fabric_model #(
    parameter int unsigned REF_HALF = 4,
    parameter int unsigned FB_HALF = 5
) (
    // Clock
    input wire logic i_mclk,
    // Run controls
    input wire logic i_ref_run,
    input wire logic i_fb_run,
    // Clocks toward the generator
    output logic o_ref_clk_in,
    output logic o_ext_fb_clk_in
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned rc = 0;
    int unsigned fc = 0;
    logic ref_q = 1'b0;
    logic fb_q = 1'b0;

    // ==========================================================
    // Reference from fabric routing
    // ==========================================================
    // Keeps running through reset, as fabric logic would
    always @(posedge i_mclk) begin
        rc <= (rc + 1) % (2 * REF_HALF);
        ref_q <= i_ref_run && (rc >= REF_HALF);
    end

    // ==========================================================
    // External feedback
    // ==========================================================
    // No divider in this route, so the factor stays at one; stands low when off
    always @(posedge i_mclk) begin
        fc <= (fc + 1) % (2 * FB_HALF);
        fb_q <= i_fb_run && (fc >= FB_HALF);
    end

    assign o_ref_clk_in = ref_q;
    assign o_ext_fb_clk_in = fb_q;
endmodule : dopcc_fabric_model

// ==== sim/dopcc_top_tb.sv ====
module dopcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned LOCK_N = 4;
    localparam int unsigned REF_HALF = 4;
    // Lock needs LOCK_N + 1 + 2 + 1 reference edges
    localparam int MIN_LOCK = (LOCK_N + 3) * 2 * REF_HALF;
    localparam dopcc_pkg::dopcc_osrc_t T0 = dopcc_pkg::SRC_TAP_ZERO;
    localparam dopcc_pkg::dopcc_osrc_t T90 = dopcc_pkg::SRC_TAP_QUARTER;
    localparam dopcc_pkg::dopcc_osrc_t FULL = dopcc_pkg::SRC_FULL;
    localparam dopcc_pkg::dopcc_osrc_t HALF = dopcc_pkg::SRC_HALVED;

    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    dopcc_pkg::dopcc_cfg_t i_cfg = '0;
    logic i_bypass = 1'b0;
    logic i_hold_outputs_req = 1'b0;
    logic [7:0] i_runtime_delay_bus = 8'h00;
    logic ref_run = 1'b1;
    logic fb_run = 1'b0;
    logic rclk;
    logic fclk;
    logic oag;
    logic oaf;
    logic obg;
    logic obf;
    logic lk;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #2 i_mclk = ~i_mclk;

    dopcc_fabric_model #(.REF_HALF(REF_HALF), .FB_HALF(5)) i_fabric (
        .i_mclk(i_mclk), .i_ref_run(ref_run), .i_fb_run(fb_run),
        .o_ref_clk_in(rclk), .o_ext_fb_clk_in(fclk));

    dopcc_top #(.LOCK_EDGES(LOCK_N), .REF_TIMEOUT(16), .EXT_DIV_FACTOR(1)) i_dut (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce), .i_cfg(i_cfg),
        .i_ref_clk_in(rclk), .i_ext_fb_clk_in(fclk), .i_bypass(i_bypass),
        .i_hold_outputs_req(i_hold_outputs_req), .i_runtime_delay_bus(i_runtime_delay_bus),
        .o_out_a_global_net(oag), .o_out_a_fabric(oaf), .o_out_b_global_net(obg),
        .o_out_b_fabric(obf), .o_lock(lk));

    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic final_report();
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        comparisons++;
        if (seen !== expected) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%0h expected=%0h", $time, seen, expected);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : tick

    function automatic dopcc_pkg::dopcc_cfg_t mk(input dopcc_pkg::dopcc_route_t rt,
        input dopcc_pkg::dopcc_osrc_t sa, input dopcc_pkg::dopcc_osrc_t sb, input logic dv,
        input logic [2:0] q, input logic gb);
        dopcc_pkg::dopcc_cfg_t c;
        c = '0;
        c.route = rt;
        c.fb_fine_delay_val = 4'hF;
        c.rel_fine_delay_src = dopcc_pkg::DS_RUNTIME;
        c.phase_div_sel = dv;
        c.out_a_src_sel = sa;
        c.out_b_src_sel = sb;
        c.ref_divider = 4'h1;
        c.fb_divider = 6'h02;
        c.osc_out_divider = q;
        c.filter_range = 3'h1;
        c.gate_en_a = !gb;
        c.gate_en_b = gb;
        return c;
    endfunction : mk

    task automatic start(input dopcc_pkg::dopcc_cfg_t c);
        @(posedge i_mclk);
        i_nrst <= 1'b0;
        i_cfg <= c;
        #1;
        check({4'h0, oag, oaf, obg, lk}, 8'h00);
        repeat (4) @(posedge i_mclk);
        i_nrst <= 1'b1;
        #1;
    endtask : start

    task automatic wait_lock(output int n);
        n = 0;
        while (lk !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
    endtask : wait_lock

    task automatic period(input logic pb, input logic [7:0] expected);
        logic prev;
        logic cur;
        int first;
        first = -1;
        prev = pb ? obg : oag;
        for (int i = 0; i < 100; i++) begin
            tick(1);
            cur = pb ? obg : oag;
            if (cur === 1'b1 && prev === 1'b0) begin
                if (first >= 0) begin
                    check(8'(i - first), expected);
                    return;
                end
                first = i;
            end
            prev = cur;
        end
        check(8'hFF, expected);
    endtask : period

    // Gated port must stand still, the other keeps toggling
    task automatic hold_chk(input logic gb);
        logic a0;
        logic b0;
        int ta;
        int tb;
        ta = 0;
        tb = 0;
        @(posedge i_mclk);
        i_hold_outputs_req <= 1'b1;
        // Bypass keeps the ungated port moving with the reference
        i_bypass <= 1'b1;
        tick(3);
        a0 = oag;
        b0 = obg;
        repeat (16) begin
            tick(1);
            ta += int'(oag !== a0);
            tb += int'(obg !== b0);
            check(8'(lk), 8'(!gb));
        end
        check(8'(ta != 0), 8'(gb));
        check(8'(tb != 0), 8'(!gb));
        @(posedge i_mclk);
        i_hold_outputs_req <= 1'b0;
        i_bypass <= 1'b0;
        tick(3);
        check(8'(lk), 8'h01);
    endtask : hold_chk

    always @(negedge i_mclk) begin
        if (i_nrst === 1'b1) begin
            check({7'h00, oaf}, {7'h00, oag});
            check({7'h00, obf}, {7'h00, obg});
        end
    end

    // Ceiling well above the thousand or so cycles the sequence needs
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end

    // ==========================================================
    // Sequence
    // ==========================================================
    initial begin
        int n;
        logic p;
        start(mk(dopcc_pkg::RT_DELAY, FULL, FULL, 1'b0, 3'h3, 1'b1));
        wait_lock(n);
        check(8'(n >= MIN_LOCK), 8'h01);
        check(8'(lk), 8'h01);
        period(1'b1, 8'h06);
        period(1'b0, 8'h06);
        // Every fine value rounds up to one cycle, so A trails B by one
        for (int k = 0; k < 16; k++) begin
            p = obg;
            @(posedge i_mclk);
            i_runtime_delay_bus <= {4'(k), 4'(15 - k)};
            #1;
            check(8'(oag), 8'(p));
        end
        hold_chk(1'b1);
        @(posedge i_mclk);
        i_bypass <= 1'b1;
        tick(2);
        repeat (16) begin
            p = rclk;
            tick(1);
            check({6'h00, oag, obg}, {6'h00, p, p});
        end
        @(posedge i_mclk);
        i_bypass <= 1'b0;
        ref_run <= 1'b0;
        tick(24);
        check(8'(lk), 8'h00);
        ref_run <= 1'b1;
        wait_lock(n);
        check(8'(lk), 8'h01);
        start(mk(dopcc_pkg::RT_EXT, HALF, FULL, 1'b0, 3'h3, 1'b0));
        wait_lock(n);
        check(8'(lk), 8'h00);
        fb_run <= 1'b1;
        wait_lock(n);
        check(8'(lk), 8'h01);
        period(1'b0, 8'h0C);
        period(1'b1, 8'h06);
        hold_chk(1'b0);
        fb_run <= 1'b0;
        for (int d = 0; d < 2; d++) begin
            start(mk(dopcc_pkg::RT_PHASE, T0, T90, 1'(d), 3'h1, 1'b0));
            wait_lock(n);
            check(8'(lk), 8'h01);
            period(1'b0, (d == 0) ? 8'h08 : 8'h0E);
            p = 1'b0;
            repeat (20) begin
                tick(1);
                p = p | obg;
            end
            check(8'(p), 8'(d == 0));
        end
        start(mk(dopcc_pkg::RT_SIMPLE, T0, FULL, 1'b0, 3'h1, 1'b0));
        wait_lock(n);
        check(8'(lk), 8'h01);
        period(1'b1, 8'h02);
        p = 1'b0;
        repeat (20) begin
            tick(1);
            p = p | oag;
        end
        check(8'(p), 8'h00);
        // Clock enable low must freeze a port toggling every cycle
        @(posedge i_mclk);
        i_ce <= 1'b0;
        tick(1);
        p = obg;
        repeat (8) begin
            tick(1);
            check({6'h00, lk, obg}, {6'h00, 1'b1, p});
        end
        @(posedge i_mclk);
        i_ce <= 1'b1;
        tick(2);
        final_report();
    end
endmodule : dopcc_top_tb
